// ==== common/psc_defs.svh ====
// register offsets, field positions, mac port codes and soft reset pulse length of the strap and power-down block
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH
`define PSC_OFF_CTRL     12'h000
`define PSC_OFF_STATUS   12'h004
`define PSC_OFF_STRAP    12'h008
`define PSC_OFF_CFG      12'h00C
`define PSC_OFF_ADDR     12'h010
// control register bits
`define PSC_CTRL_SPD     0
`define PSC_CTRL_SRST    1
`define PSC_CTRL_POL     2
// status register bits
`define PSC_ST_SPD_ACT   0
`define PSC_ST_LINK      1
`define PSC_ST_AN_RUN    2
// configuration register bits
`define PSC_CFG_ADV      0
`define PSC_CFG_FORCED   1
`define PSC_CFG_HISWING  2
`define PSC_CFG_CONV     3
`define PSC_CFG_MAC_LO   4
// mac port codes
`define PSC_MAC_RMII     2'h0
`define PSC_MAC_RGMII    2'h1
`define PSC_MAC_RSVD     2'h2
`define PSC_MAC_MII      2'h3
// soft reset pulse length in cycles
`define PSC_SRST_CYC     4'h8
`endif

// ==== common/psc_pkg.sv ====
// types for the strap and power-down block
package psc_pkg;
  typedef enum logic [1:0] {PSC_ST_SAMPLE, PSC_ST_POWERDOWN, PSC_ST_ACTIVE} psc_mode_t;
  typedef struct packed {
    logic [2:0] phy_addr;
    logic       pd_after_rst;
    logic       role;
    logic       amp_limit;
    logic [1:0] mac_sel;
    logic       conv;
  } psc_strap_t;
  typedef struct packed {
    psc_mode_t  mode;
    psc_strap_t strap;
    logic       spd_req;
    logic       pol;
    logic       adv_role;
    logic       forced_role;
    logic       hi_swing;
    logic       conv_en;
    logic [3:0] srst_cnt;
    logic       link_pin;
    logic       mac_zero;
    logic       line_en;
    logic       an_start;
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
    logic       io_en;
  } psc_state_t;
endpackage

// ==== logic/psc_strap_powerdown.sv ====
// strap latch, power-down control and link indicator with apb registers
`timescale 1ns/1ps
`include "psc_defs.svh"
module psc_strap_powerdown
  import psc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // strap pins, sampled after reset
  input  wire logic        phy_address_strap_bit0,
  input  wire logic        phy_address_strap_bit1,
  input  wire logic        phy_address_strap_bit2,
  input  wire logic        powerdown_after_reset_strap,
  input  wire logic        role_preference_strap,
  input  wire logic        amplitude_limit_strap,
  input  wire logic        mac_port_select_strap0,
  input  wire logic        mac_port_select_strap1,
  input  wire logic        converter_mode_strap,
  // phy core status
  input  wire logic        link_status,
  input  wire logic        an_enable,
  input  wire logic        an_complete,
  // outputs to the phy core and pins
  output logic             link_up_indicator,
  output logic             pins_out_en,
  output logic             mac_out_force_low,
  output logic             line_enable,
  output logic             an_start,
  output logic             soft_powerdown_active,
  output logic             soft_reset_pulse
);

  psc_state_t s_q;
  psc_state_t s_d;

  // decode of an apb word address against one register
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  // true for the mode that holds the phy in soft power-down
  function automatic logic in_pd(input psc_mode_t m);
    in_pd = (m == PSC_ST_POWERDOWN);
  endfunction

  // true for any mapped register offset
  function automatic logic mapped(input logic [11:0] a);
    mapped = hit(a, `PSC_OFF_CTRL) || hit(a, `PSC_OFF_STATUS) || hit(a, `PSC_OFF_STRAP)
             || hit(a, `PSC_OFF_CFG) || hit(a, `PSC_OFF_ADDR);
  endfunction

  // control word as read back
  function automatic logic [31:0] ctrl_word(input psc_state_t s);
    ctrl_word = 32'h0;
    ctrl_word[`PSC_CTRL_SPD] = s.spd_req;
    ctrl_word[`PSC_CTRL_POL] = s.pol;
  endfunction

  // status word, read only
  function automatic logic [31:0] status_word(input psc_state_t s,
                                              input logic       lnk,
                                              input logic       an_en);
    status_word = 32'h0;
    status_word[`PSC_ST_SPD_ACT] = in_pd(s.mode);
    status_word[`PSC_ST_LINK] = lnk && s.line_en;
    status_word[`PSC_ST_AN_RUN] = an_en;
  endfunction

  // configuration word as read back
  function automatic logic [31:0] cfg_word(input psc_state_t s);
    cfg_word = 32'h0;
    cfg_word[`PSC_CFG_ADV] = s.adv_role;
    cfg_word[`PSC_CFG_FORCED] = s.forced_role;
    cfg_word[`PSC_CFG_HISWING] = s.hi_swing;
    cfg_word[`PSC_CFG_CONV] = s.conv_en;
    cfg_word[`PSC_CFG_MAC_LO+1:`PSC_CFG_MAC_LO] = s.strap.mac_sel;
  endfunction

  // read mux over the register map; unmapped reads give zero
  function automatic logic [31:0] read_word(input psc_state_t  s,
                                            input logic [11:0] a,
                                            input logic        lnk,
                                            input logic        an_en);
    read_word = 32'h0;
    if (hit(a, `PSC_OFF_CTRL))
    begin
      read_word = ctrl_word(s);
    end
    else if (hit(a, `PSC_OFF_STATUS))
    begin
      read_word = status_word(s, lnk, an_en);
    end
    else if (hit(a, `PSC_OFF_STRAP))
    begin
      read_word = {23'h0, s.strap};
    end
    else if (hit(a, `PSC_OFF_CFG))
    begin
      read_word = cfg_word(s);
    end
    else if (hit(a, `PSC_OFF_ADDR))
    begin
      read_word = {29'h0, s.strap.phy_addr};
    end
  endfunction

  // next-state logic
  always_comb
  begin
    logic acc_new;
    logic acc_done;
    logic wr;
    logic sw_rst;
    acc_new  = 1'b0;
    acc_done = 1'b0;
    wr       = 1'b0;
    sw_rst   = 1'b0;
    s_d = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.an_start = 1'b0;
    if (s_q.srst_cnt != 4'h0)
    begin
      s_d.srst_cnt = s_q.srst_cnt - 4'h1;
    end
    unique case (s_q.mode)
      PSC_ST_SAMPLE:
      begin
        // straps latched once, held until next reset event
        s_d.strap.phy_addr = {phy_address_strap_bit2, phy_address_strap_bit1,
                              phy_address_strap_bit0};
        s_d.strap.pd_after_rst = powerdown_after_reset_strap;
        s_d.strap.role = role_preference_strap;
        s_d.strap.amp_limit = amplitude_limit_strap;
        s_d.strap.mac_sel = {mac_port_select_strap1, mac_port_select_strap0};
        s_d.strap.conv = converter_mode_strap;
        // strap level 0 means power down after reset
        s_d.spd_req = ~powerdown_after_reset_strap;
        s_d.adv_role = role_preference_strap;
        s_d.forced_role = role_preference_strap;
        s_d.hi_swing = ~amplitude_limit_strap;
        // converter only meaningful in rmii; rgmii needs no setting
        s_d.conv_en = converter_mode_strap &&
                      ({mac_port_select_strap1, mac_port_select_strap0} == `PSC_MAC_RMII);
        s_d.io_en = 1'b1;
        if (~powerdown_after_reset_strap)
        begin
          s_d.mode = PSC_ST_POWERDOWN;
        end
        else
        begin
          s_d.mode = PSC_ST_ACTIVE;
          s_d.an_start = an_enable;
        end
      end
      PSC_ST_POWERDOWN:
      begin
        // only the spd control bit or a software reset releases power-down
        if (!s_q.spd_req)
        begin
          s_d.mode = PSC_ST_ACTIVE;
          s_d.an_start = an_complete;
        end
      end
      PSC_ST_ACTIVE:
      begin
        if (s_q.spd_req)
        begin
          s_d.mode = PSC_ST_POWERDOWN;
        end
      end
      default:
      begin
        // unused code: go back and sample again
        s_d.mode = PSC_ST_SAMPLE;
      end
    endcase
    // first access-phase edge: answer with data on the next cycle
    acc_new  = psel && penable && !s_q.pready;
    // edge at which the master samples the answer: writes land here only
    acc_done = psel && penable && s_q.pready;
    wr       = acc_done && pwrite && mapped(paddr);
    if (acc_new)
    begin
      s_d.pready  = 1'b1;
      s_d.prdata  = read_word(s_q, paddr, link_status, an_enable);
      s_d.pslverr = !mapped(paddr);
    end
    // control register write
    if (wr && hit(paddr, `PSC_OFF_CTRL))
    begin
      s_d.spd_req = pwdata[`PSC_CTRL_SPD];
      s_d.pol     = pwdata[`PSC_CTRL_POL];
      sw_rst      = pwdata[`PSC_CTRL_SRST];
    end
    // configuration register write
    if (wr && hit(paddr, `PSC_OFF_CFG))
    begin
      s_d.adv_role    = pwdata[`PSC_CFG_ADV];
      s_d.forced_role = pwdata[`PSC_CFG_FORCED];
      // high swing locked off when amplitude strap was high
      s_d.hi_swing    = pwdata[`PSC_CFG_HISWING] && !s_q.strap.amp_limit;
      s_d.conv_en     = pwdata[`PSC_CFG_CONV];
    end
    // software reset: pins tristate, straps sampled again, polarity back to high
    if (sw_rst)
    begin
      s_d.mode = PSC_ST_SAMPLE;
      s_d.pol = 1'b0;
      s_d.io_en = 1'b0;
      s_d.srst_cnt = `PSC_SRST_CYC;
    end
    // outputs derived from the next mode
    s_d.line_en = (s_d.mode == PSC_ST_ACTIVE);
    s_d.mac_zero = (s_d.mode == PSC_ST_POWERDOWN);
    s_d.link_pin = (link_status && s_d.line_en) ^ s_d.pol;
  end

  // state register, reset gives hardware power-down
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.mode <= PSC_ST_SAMPLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops; soft_reset_pulse decoded from the counter
  assign pready = s_q.pready;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign link_up_indicator = s_q.link_pin;
  assign pins_out_en = s_q.io_en;
  assign mac_out_force_low = s_q.mac_zero;
  assign line_enable = s_q.line_en;
  assign an_start = s_q.an_start;
  assign soft_powerdown_active = s_q.mac_zero;
  assign soft_reset_pulse = (s_q.srst_cnt != 4'h0);

endmodule

// ==== testbench/psc_sp_assertions.sv ====
// checker for the strap and power-down block
`timescale 1ns/1ps
module psc_sp_chk
  import psc_pkg::*;
(
  // clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // power-down outputs
  input wire logic pins_out_en,
  input wire logic mac_out_force_low,
  input wire logic line_enable,
  input wire logic an_start,
  input wire logic soft_powerdown_active,
  input wire logic soft_reset_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // reset, bus answer and power-down relations
  a_hw_pd: assert property (disable iff (1'b0) !presetn |-> !pins_out_en && !pready)
    else $error("active in reset");
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready long");
  a_rdy_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  a_rdy_cause: assert property (pready |-> $past(psel && penable))
    else $error("stray pready");
  a_err_qual: assert property (pslverr |-> pready)
    else $error("stray pslverr");
  a_line_pd: assert property (!(line_enable && soft_powerdown_active))
    else $error("line on in pd");
  a_mac_low: assert property (mac_out_force_low == (pins_out_en && !line_enable))
    else $error("mac not low");
  a_pd_exit: assert property ($fell(soft_powerdown_active) |-> pready && pwrite
    || $past(pready && pwrite) || $past(pready && pwrite, 2) || $past(soft_reset_pulse))
    else $error("pd left alone");
  a_an_pulse: assert property (an_start |=> !an_start)
    else $error("an_start long");
  // main scenarios
  c_exit: cover property ($fell(soft_powerdown_active));
  c_err: cover property (pslverr);
  c_srst: cover property ($fell(soft_reset_pulse));
endmodule
bind psc_strap_powerdown psc_sp_chk psc_sp_chk_i (.*);

// ==== testbench/psc_strap_model.sv ====
// board straps and later pin activity
`timescale 1ns/1ps
module psc_strap_model
  import psc_pkg::*;
(
  // clock and control
  input  wire logic       pclk,
  input  wire psc_strap_t want,
  input  wire logic       float_en,
  input  wire logic       func_en,
  // strap pins
  output psc_strap_t      pins
);
  psc_strap_t wig_q;
  // pins in functional use change every cycle
  always_ff @(posedge pclk)
    wig_q <= func_en ? ~wig_q : ~want;
  // floating pins pulled low
  assign pins = func_en ? wig_q : (float_en ? '0 : want);
endmodule

// ==== testbench/tb_top.sv ====
// testbench for the strap and power-down block
`timescale 1ns/1ps
`include "psc_defs.svh"
module tb_top
  import psc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic pready, pslverr, err, link_status = 0, an_enable = 1, an_complete = 1;
  logic pins_out_en, mac_out_force_low, line_enable, an_start, link_up_indicator;
  logic soft_powerdown_active, soft_reset_pulse, fl = 1, fn = 0;
  psc_strap_t want = '0, pins;
  int n_mismatch = 0, tests_run = 0;
  always #10 pclk = ~pclk;
  psc_strap_model psc_strap_model_i (.pclk, .want, .float_en(fl), .func_en(fn), .pins);
  psc_strap_powerdown psc_strap_powerdown_i (.*, .phy_address_strap_bit0(pins.phy_addr[0]),
    .phy_address_strap_bit1(pins.phy_addr[1]), .phy_address_strap_bit2(pins.phy_addr[2]),
    .powerdown_after_reset_strap(pins.pd_after_rst), .role_preference_strap(pins.role),
    .amplitude_limit_strap(pins.amp_limit), .mac_port_select_strap0(pins.mac_sel[0]),
    .mac_port_select_strap1(pins.mac_sel[1]), .converter_mode_strap(pins.conv));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 50 && pready !== 1'b1; i++)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    chk("apb wait", i < 50, 1);
    if (i >= 50)
      end_sim();
    @(posedge pclk);
  endtask
  task automatic wait_pulse(logic v);
    int i;
    for (i = 0; i < 20 && soft_reset_pulse !== v; i++)
      @(posedge pclk);
    chk("srst wait", i < 20, 1);
    if (i >= 20)
      end_sim();
  endtask
  function automatic logic [31:0] cfg_exp(psc_strap_t s);
    return {26'h0, s.mac_sel, s.conv && s.mac_sel == `PSC_MAC_RMII, !s.amp_limit, s.role, s.role};
  endfunction
  // read back the strap, address, configuration and status registers
  task automatic chk_all(psc_strap_t s);
    apb(0, `PSC_OFF_STRAP, 0);
    chk("strap", rd, {23'h0, s});
    apb(0, `PSC_OFF_ADDR, 0);
    chk("addr", rd, {29'h0, s.phy_addr});
    apb(0, `PSC_OFF_CFG, 0);
    chk("cfg", rd, cfg_exp(s));
    apb(0, `PSC_OFF_STATUS, 0);
    chk("pd", rd[0], !s.pd_after_rst);
  endtask
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'hA3EFEB98));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk_all('0);
    apb(1, `PSC_OFF_CTRL, 32'h4);
    @(negedge pclk);
    chk("an start", an_start, 1);
    chk("pins", pins_out_en, 1);
    repeat (2) @(posedge pclk);
    chk("spd", soft_powerdown_active, 0);
    chk("link", link_up_indicator, 1);
    apb(1, `PSC_OFF_CTRL, 32'h1);
    repeat (2) @(posedge pclk);
    chk("spd", soft_powerdown_active, 1);
    chk("line", line_enable, 0);
    chk("mac low", mac_out_force_low, 1);
    apb(0, 12'h014, 0);
    chk("unmapped", err, 1);
    $display("test fixed done");
    repeat (6)
    begin
      want <= 9'($urandom);
      fl <= 0;
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk_all(want);
      fn <= 1;
      repeat (3) @(posedge pclk);
      apb(0, `PSC_OFF_STRAP, 0);
      chk("held", rd, {23'h0, want});
      apb(1, `PSC_OFF_CFG, 32'h7);
      apb(0, `PSC_OFF_CFG, 0);
      chk("cfg wr", rd[2:0], {!want.amp_limit, 2'h3});
      fn <= 0;
      want <= 9'($urandom);
      apb(1, `PSC_OFF_CTRL, 32'h2);
      wait_pulse(1);
      wait_pulse(0);
      repeat (2) @(posedge pclk);
      chk_all(want);
      $display("test random done");
    end
    end_sim();
  end
endmodule
